/* rtl/sdc_pkg.sv */
/*
  Shared constants and types for the synchronous DRAM command block.
  Assumes a single 50 MHz clock and commands sampled on its rising edge.
*/
package sdc_pkg;
  localparam int ROW_W = 12;
  localparam int COL_W = 8;
  localparam int BANK_W = 2;
  localparam int BANKS = 4;
  localparam int DQ_W = 16;
  localparam int LANES = 2;
  localparam int LANE_W = 8;
  localparam int AP_BIT = 10;
  localparam int MEM_COL_W = 4;
  localparam int MEM_IDX_W = BANK_W + MEM_COL_W;
  localparam int MEM_DEPTH = 64;
  localparam int FIFO_DEPTH = 4;
  localparam int REF_CNT_W = BANK_W + ROW_W;
  localparam logic [ROW_W-1:0] MODE_RST = 12'h000;
  localparam int BL_LSB = 0;
  localparam int CL_LSB = 4;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL_3 = 3'h3;
  localparam int CLK_MHZ = 50;
  localparam int REFRESH_WINDOW_MS = 64;
  localparam int REFRESH_ROWS = 4096;
  localparam int SELF_TICK_NS = REFRESH_WINDOW_MS * 1000000 / REFRESH_ROWS;
  localparam int SELF_TICK_CYC = SELF_TICK_NS * CLK_MHZ / 1000;
  localparam int TICK_W = 10;
  // {cs, row strobe, column strobe, write strobe}, all active low
  typedef enum logic [3:0] {
    SDC_LMR = 4'h0,
    SDC_REF = 4'h1,
    SDC_PRE = 4'h2,
    SDC_ACT = 4'h3,
    SDC_WR = 4'h4,
    SDC_RD = 4'h5,
    SDC_BST = 4'h6,
    SDC_NOP = 4'h7
  } sdc_cmd_t;
  typedef enum logic [0:0] {
    SDC_RUN = 1'b0,
    SDC_SELF = 1'b1
  } sdc_pwr_t;
  typedef struct packed {
    logic [MEM_IDX_W-1:0] idx;
    logic [LANES-1:0] mask;
    logic [DQ_W-1:0] data;
  } sdc_wr_t;
  typedef struct packed {
    logic valid;
    logic [DQ_W-1:0] data;
  } sdc_rd_t;
endpackage : sdc_pkg

/* rtl/sdc_device.sv */
/*
  Synchronous DRAM device command logic with a write FIFO and a small
  flop array. Assumes the controller drives all inputs synchronous to clk.
*/
// Contract
// - READ bursts from bank at given column
// - Flag line high closes row after read
// - Read lanes follow mask two clocks earlier
// - WRITE bursts into bank, flag picks precharge
// - Write mask in same cycle blocks byte
// - PRECHARGE closes one bank or all
// - Auto precharge closes row after burst
// - Refresh row and bank generated internally
// - Clock enable fall enters self refresh
// - Self refresh holds while enable low
// - BURST TERMINATE truncates latest burst
// - Inhibit registers nothing, work continues
// - NOP registers no command
// - Mode register loads only when idle
// - ACTIVE opens row until precharge
// - Encodings for inhibit, NOP, ACTIVE, READ, WRITE
// - Encodings for terminate, precharge, refresh, mode
// - Refresh code with enable low enters self
// - Two masks govern lower and upper bytes
`timescale 1ns/1ns
`default_nettype none

module sdc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic rdy_r, rdy_nxt;
  logic push, pop;

  // Ready comes from a flop so the port carries no comparator
  assign in_ready = rdy_r;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    wp_nxt = push ? AW'((wp_r + 1'b1) % DEPTH) : wp_r;
    rp_nxt = pop ? AW'((rp_r + 1'b1) % DEPTH) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    rdy_nxt = (cnt_nxt != FULL_CNT);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b1;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  for (genvar e = 0; e < DEPTH; e++) begin : g_ent
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        mem_r[e] <= '0;
      end else if (push && wp_r == AW'(e)) begin
        mem_r[e] <= in_data;
      end
    end
  end
endmodule : sdc_fifo

module sdc_device
  import sdc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_lo,
  input wire logic bank_select_hi,
  input wire logic [ROW_W-1:0] addr,
  input wire logic lower_byte_mask,
  input wire logic upper_byte_mask,
  input wire logic [DQ_W-1:0] dq_in,
  output logic [DQ_W-1:0] dq_out,
  output logic [LANES-1:0] dq_oe,
  output logic write_ready,
  output logic [BANKS-1:0] bank_open,
  output logic [ROW_W-1:0] mode_reg,
  output logic self_refresh,
  output logic [REF_CNT_W-1:0] refresh_count
);
  logic [BANK_W-1:0] bank;
  logic precharge_flag_line;
  logic [LANES-1:0] mask;
  logic [3:0] cmd;
  logic go, beat, cl3;
  logic [8:0] bl_len;
  logic [BANKS-1:0] open_r, open_nxt;
  logic [ROW_W-1:0] row_r [BANKS];
  logic [ROW_W-1:0] row_nxt [BANKS];
  logic [ROW_W-1:0] mode_r, mode_nxt;
  sdc_pwr_t pwr_r, pwr_nxt;
  logic cke_prev_r;
  logic [REF_CNT_W-1:0] ref_r, ref_nxt;
  logic [TICK_W-1:0] tick_r, tick_nxt;
  logic burst_r, burst_nxt, wr_r, wr_nxt, ap_r, ap_nxt, full_r, full_nxt;
  logic [BANK_W-1:0] bb_r, bb_nxt;
  logic [COL_W-1:0] col_r, col_nxt;
  logic [8:0] left_r, left_nxt;
  logic wr_push, rd_fetch, is_rw;
  logic [MEM_IDX_W-1:0] acc_idx;
  sdc_wr_t push_w, pop_w;
  logic pop_valid, pop_ready;
  logic [DQ_W-1:0] mem_r [MEM_DEPTH];
  sdc_rd_t p1_r, p1_nxt, p2_r, p2_nxt, sel;
  logic [LANES-1:0] dqm_d1_r, oe_nxt, oe_r;
  logic [DQ_W-1:0] dq_nxt, dq_r;

  assign bank = {bank_select_hi, bank_select_lo};
  assign precharge_flag_line = addr[AP_BIT];
  assign mask = {upper_byte_mask, lower_byte_mask};
  // command decode, chip select high is inhibit
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  // inhibit and NOP fall to no action below
  assign go = cke & (pwr_r == SDC_RUN) & ~cs_n;
  assign beat = burst_r & cke & (pwr_r == SDC_RUN);
  assign cl3 = (mode_r[CL_LSB +: 3] == CL_3);
  assign is_rw = go & (cmd == SDC_RD || cmd == SDC_WR);

  always_comb begin
    case (mode_r[BL_LSB +: 3])
      BL_2: bl_len = 9'h002;
      BL_4: bl_len = 9'h004;
      BL_8: bl_len = 9'h008;
      BL_FULL: bl_len = 9'h100;
      default: bl_len = 9'h001;
    endcase
  end

  always_comb begin
    open_nxt = open_r;
    row_nxt = row_r;
    mode_nxt = mode_r;
    pwr_nxt = pwr_r;
    ref_nxt = ref_r;
    tick_nxt = tick_r;
    burst_nxt = burst_r;
    wr_nxt = wr_r;
    ap_nxt = ap_r;
    full_nxt = full_r;
    bb_nxt = bb_r;
    col_nxt = col_r;
    left_nxt = left_r;
    // close at last beat, full page wraps until stopped
    if (beat) begin
      col_nxt = col_r + 8'h01;
      if (!full_r) begin
        left_nxt = left_r - 9'h001;
        if (left_r == 9'h001) begin
          burst_nxt = 1'b0;
          if (ap_r) begin
            open_nxt[bb_r] = 1'b0;
          end
        end
      end
    end
    if (go) begin
      case (cmd)
        SDC_ACT: begin
          open_nxt[bank] = 1'b1;
          row_nxt[bank] = addr;
        end
        SDC_RD, SDC_WR: begin
          wr_nxt = (cmd == SDC_WR);
          bb_nxt = bank;
          col_nxt = addr[COL_W-1:0] + 8'h01;
          left_nxt = bl_len - 9'h001;
          full_nxt = (bl_len == 9'h100);
          burst_nxt = (bl_len != 9'h001);
          ap_nxt = precharge_flag_line;
          if (bl_len == 9'h001 && precharge_flag_line) begin
            open_nxt[bank] = 1'b0;
          end
        end
        SDC_BST: begin
          burst_nxt = 1'b0;
        end
        SDC_PRE: begin
          if (precharge_flag_line) begin
            open_nxt = '0;
            burst_nxt = 1'b0;
          end else begin
            open_nxt[bank] = 1'b0;
            if (bank == bb_r) begin
              burst_nxt = 1'b0;
            end
          end
        end
        SDC_REF: begin
          ref_nxt = ref_r + 14'h0001;
        end
        SDC_LMR: begin
          if (open_r == '0) begin
            mode_nxt = addr;
          end
        end
        default: begin
        end
      endcase
    end
    case (pwr_r)
      SDC_RUN: begin
        if (cke_prev_r && !cke && !cs_n && cmd == SDC_REF) begin
          pwr_nxt = SDC_SELF;
          tick_nxt = '0;
          burst_nxt = 1'b0;
        end
      end
      SDC_SELF: begin
        if (tick_r == TICK_W'(SELF_TICK_CYC - 1)) begin
          tick_nxt = '0;
          ref_nxt = ref_r + 14'h0001;
        end else begin
          tick_nxt = tick_r + 10'h001;
        end
        if (cke) begin
          pwr_nxt = SDC_RUN;
        end
      end
      default: pwr_nxt = SDC_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      open_r <= '0;
      row_r <= '{default: '0};
      mode_r <= MODE_RST;
      pwr_r <= SDC_RUN;
      cke_prev_r <= 1'b0;
      ref_r <= '0;
      tick_r <= '0;
      burst_r <= 1'b0;
      wr_r <= 1'b0;
      ap_r <= 1'b0;
      full_r <= 1'b0;
      bb_r <= '0;
      col_r <= '0;
      left_r <= '0;
    end else begin
      open_r <= open_nxt;
      row_r <= row_nxt;
      mode_r <= mode_nxt;
      pwr_r <= pwr_nxt;
      cke_prev_r <= cke;
      ref_r <= ref_nxt;
      tick_r <= tick_nxt;
      burst_r <= burst_nxt;
      wr_r <= wr_nxt;
      ap_r <= ap_nxt;
      full_r <= full_nxt;
      bb_r <= bb_nxt;
      col_r <= col_nxt;
      left_r <= left_nxt;
    end
  end

  // Any other command in the cycle cuts the running beat
  always_comb begin
    wr_push = 1'b0;
    rd_fetch = 1'b0;
    acc_idx = {bb_r, col_r[MEM_COL_W-1:0]};
    if (is_rw) begin
      wr_push = (cmd == SDC_WR);
      rd_fetch = (cmd == SDC_RD);
      acc_idx = {bank, addr[MEM_COL_W-1:0]};
    end else if (beat && !(go && cmd != SDC_NOP)) begin
      wr_push = wr_r;
      rd_fetch = ~wr_r;
    end
  end

  assign push_w = '{idx: acc_idx, mask: mask, data: dq_in};
  // Reads own the array port; the FIFO backs up while a read runs
  assign pop_ready = ~rd_fetch;

  sdc_fifo #(
    .WIDTH($bits(sdc_wr_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(wr_push),
    .in_ready(write_ready),
    .in_data(push_w),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_w)
  );

  for (genvar w = 0; w < MEM_DEPTH; w++) begin : g_word
    for (genvar l = 0; l < LANES; l++) begin : g_lane
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          mem_r[w][l*LANE_W +: LANE_W] <= '0;
        end else if (pop_valid && pop_ready && pop_w.idx == MEM_IDX_W'(w)
                     && !pop_w.mask[l]) begin
          mem_r[w][l*LANE_W +: LANE_W] <= pop_w.data[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  always_comb begin
    p1_nxt = p1_r;
    p2_nxt = p2_r;
    if (cke) begin
      p1_nxt = '{valid: rd_fetch, data: mem_r[acc_idx]};
      p2_nxt = p1_r;
    end
    sel = cl3 ? p2_r : p1_r;
    dq_nxt = sel.data;
    // mask registered one edge before the data edge
    oe_nxt = {LANES{sel.valid}} & ~dqm_d1_r;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      p1_r <= '0;
      p2_r <= '0;
      dqm_d1_r <= '1;
      oe_r <= '0;
      dq_r <= '0;
    end else begin
      p1_r <= p1_nxt;
      p2_r <= p2_nxt;
      dqm_d1_r <= mask;
      oe_r <= oe_nxt;
      dq_r <= dq_nxt;
    end
  end

  assign dq_out = dq_r;
  assign dq_oe = oe_r;
  assign bank_open = open_r;
  assign mode_reg = mode_r;
  assign self_refresh = (pwr_r == SDC_SELF);
  assign refresh_count = ref_r;
endmodule : sdc_device

`default_nettype wire

/* tb/sdc_ctl_model.sv */
/*
  Behavioural memory controller that drives the device command pins.
  Assumes the bench calls its tasks from one process, off clk edges.
*/
`timescale 1ns/1ns
`default_nettype none
module sdc_ctl_model
  import sdc_pkg::*;
#(
  parameter int PRECHARGE_RECOVERY_TIME = 2,
  parameter int ROW_CYCLE_TIME = 4
) (
  input wire logic clk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic bank_select_lo,
  output logic bank_select_hi,
  output logic [ROW_W-1:0] addr,
  output logic lower_byte_mask,
  output logic upper_byte_mask,
  output logic [DQ_W-1:0] dq_in
);
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
    {bank_select_hi, bank_select_lo, addr, upper_byte_mask, lower_byte_mask, dq_in} = '0;
  end
  task automatic send(input sdc_cmd_t c, input logic [1:0] b, input logic [11:0] a,
                      input logic [1:0] m, input logic [15:0] d);
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= c;
    {bank_select_hi, bank_select_lo} <= b;
    addr <= a;
    {upper_byte_mask, lower_byte_mask} <= m;
    dq_in <= d;
  endtask : send
  // idle NOPs; released lines toggle so stale values never look valid
  task automatic nop(input int n);
    repeat (n) begin
      @(posedge clk);
      {cs_n, ras_n, cas_n, we_n} <= SDC_NOP;
      addr <= ~addr;
      dq_in <= ~dq_in;
    end
  endtask : nop
  // refresh on demand; runs stay far inside one window
  task automatic cmd(input sdc_cmd_t c, input logic [1:0] b, input logic [11:0] a,
                     input logic [1:0] m, input logic [15:0] d);
    send(c, b, a, m, d);
    nop((c == SDC_PRE) ? PRECHARGE_RECOVERY_TIME : (c == SDC_REF) ? ROW_CYCLE_TIME : 1);
    #1;
  endtask : cmd
  // entry, then garbage the device must ignore
  task automatic sr_enter(input int n);
    @(posedge clk);
    cke <= 1'b0;
    {cs_n, ras_n, cas_n, we_n} <= SDC_REF;
    repeat (n) begin
      @(posedge clk);
      {cs_n, ras_n, cas_n, we_n} <= SDC_ACT;
      addr <= ~addr;
    end
    #1;
  endtask : sr_enter
  // NOPs through the row cycle after exit
  task automatic sr_exit;
    @(posedge clk);
    cke <= 1'b1;
    {cs_n, ras_n, cas_n, we_n} <= SDC_NOP;
    nop(ROW_CYCLE_TIME);
    #1;
  endtask : sr_exit
endmodule : sdc_ctl_model
`default_nettype wire

/* tb/sdc_device_assertions.sv */
/*
  Port-level checker for the DRAM command block, bound to sdc_device.
  Assumes only the top module's ports are visible.
*/
`timescale 1ns/1ns
`default_nettype none
module sdc_chk
  import sdc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_lo,
  input wire logic bank_select_hi,
  input wire logic [ROW_W-1:0] addr,
  input wire logic lower_byte_mask,
  input wire logic upper_byte_mask,
  input wire logic [DQ_W-1:0] dq_in,
  input wire logic [DQ_W-1:0] dq_out,
  input wire logic [LANES-1:0] dq_oe,
  input wire logic write_ready,
  input wire logic [BANKS-1:0] bank_open,
  input wire logic [ROW_W-1:0] mode_reg,
  input wire logic self_refresh,
  input wire logic [REF_CNT_W-1:0] refresh_count
);
  logic [3:0] cmd;
  logic live;
  logic cke_r;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign live = cke && !self_refresh;
  // Own copy of the previous enable, reset low like the device's
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cke_r <= 1'b0;
    end else begin
      cke_r <= cke;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_act;
    live && cmd == SDC_ACT |=> bank_open[$past({bank_select_hi, bank_select_lo})];
  endproperty
  a_act: assert property (p_act) else $error("row not opened");
  property p_pre;
    live && cmd == SDC_PRE && addr[AP_BIT] |=> bank_open == '0;
  endproperty
  a_pre: assert property (p_pre) else $error("banks left open");
  property p_ref;
    live && cmd == SDC_REF |=> refresh_count == REF_CNT_W'($past(refresh_count) + 1);
  endproperty
  a_ref: assert property (p_ref) else $error("refresh count wrong");
  property p_inh;
    live && (cs_n || cmd == SDC_NOP) |=> $stable(mode_reg) && $stable(refresh_count);
  endproperty
  a_inh: assert property (p_inh) else $error("idle cycle changed state");
  property p_lmr;
    live && cmd == SDC_LMR && bank_open == '0 |=> mode_reg == $past(addr);
  endproperty
  a_lmr: assert property (p_lmr) else $error("mode not loaded");
  property p_sr_in;
    !self_refresh && !cke && cke_r && cmd == SDC_REF |=> self_refresh ##1 $stable(bank_open);
  endproperty
  a_sr_in: assert property (p_sr_in) else $error("self refresh not entered");
  property p_sr_out;
    self_refresh |=> self_refresh == !$past(cke);
  endproperty
  a_sr_out: assert property (p_sr_out) else $error("self refresh level wrong");
  property p_oe;
    (dq_oe & $past({upper_byte_mask, lower_byte_mask}, 2)) == '0;
  endproperty
  a_oe: assert property (p_oe) else $error("masked lane driven");
  c_rd: cover property (live && cmd == SDC_RD);
  c_wr: cover property (live && cmd == SDC_WR);
  c_sr: cover property ($rose(self_refresh));
endmodule : sdc_chk
bind sdc_device sdc_chk i_sdc_chk (.clk, .resetn, .cke, .cs_n, .ras_n, .cas_n, .we_n,
  .bank_select_lo, .bank_select_hi, .addr, .lower_byte_mask, .upper_byte_mask, .dq_in,
  .dq_out, .dq_oe, .write_ready, .bank_open, .mode_reg, .self_refresh, .refresh_count);
`default_nettype wire

/* tb/tb_top.sv */
/*
  Self-checking bench for the DRAM command block.
  Assumes the controller model drives every command pin.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("wrong value %s exp %h got %h", n, e, g); \
  end \
end
module tb_top
  import sdc_pkg::*;
;
  logic clk = 1'b0;
  logic resetn;
  wire logic cke, cs_n, ras_n, cas_n, we_n, bank_select_lo, bank_select_hi;
  wire logic lower_byte_mask, upper_byte_mask;
  wire logic [ROW_W-1:0] addr;
  wire logic [DQ_W-1:0] dq_in;
  logic [DQ_W-1:0] dq_out;
  logic [LANES-1:0] dq_oe;
  logic [BANKS-1:0] bank_open;
  logic [ROW_W-1:0] mode_reg;
  logic [REF_CNT_W-1:0] refresh_count;
  logic write_ready, self_refresh;
  int mismatches = 0;
  int cmp_count = 0;
  always #10 clk = ~clk;
  sdc_device i_sdc_device (
    .clk(clk), .resetn(resetn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_select_lo(bank_select_lo), .bank_select_hi(bank_select_hi),
    .addr(addr), .lower_byte_mask(lower_byte_mask), .upper_byte_mask(upper_byte_mask),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .write_ready(write_ready),
    .bank_open(bank_open), .mode_reg(mode_reg), .self_refresh(self_refresh),
    .refresh_count(refresh_count)
  );
  sdc_ctl_model i_sdc_ctl_model (
    .clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_select_lo(bank_select_lo), .bank_select_hi(bank_select_hi), .addr(addr),
    .lower_byte_mask(lower_byte_mask), .upper_byte_mask(upper_byte_mask), .dq_in(dq_in)
  );
  task automatic op(input sdc_cmd_t k, input logic [1:0] b, input logic [11:0] a,
                    input logic [1:0] m, input logic [15:0] d);
    i_sdc_ctl_model.cmd(k, b, a, m, d);
  endtask : op
  task automatic rd(input logic [1:0] b, input logic [11:0] a, input logic [1:0] m,
                    input logic [15:0] d, input logic [1:0] oe);
    logic [15:0] keep;
    keep = {{8{oe[1]}}, {8{oe[0]}}};
    i_sdc_ctl_model.send(SDC_RD, b, a, m, 16'h0000);
    i_sdc_ctl_model.nop(1);
    @(posedge clk);
    #1;
    `CHK("read lanes", oe, dq_oe)
    `CHK("read data", d & keep, dq_out & keep)
  endtask : rd
  task automatic t_rw;
    op(SDC_ACT, 2'h1, 12'h005, 2'h0, 16'h0000);
    `CHK("open", 4'h2, bank_open)
    op(SDC_LMR, 2'h0, 12'h023, 2'h0, 16'h0000);
    `CHK("mode busy", 12'h000, mode_reg)
    op(SDC_WR, 2'h1, 12'h003, 2'h0, 16'h1234);
    op(SDC_WR, 2'h1, 12'h003, 2'h2, 16'hABCD);
    rd(2'h1, 12'h003, 2'h0, 16'h12CD, 2'h3);
    rd(2'h1, 12'h003, 2'h1, 16'h12CD, 2'h2);
    `CHK("kept open", 4'h2, bank_open)
    $display("test rw done");
  endtask : t_rw
  task automatic t_pre;
    op(SDC_ACT, 2'h0, 12'h001, 2'h0, 16'h0000);
    op(SDC_ACT, 2'h2, 12'h002, 2'h0, 16'h0000);
    op(SDC_PRE, 2'h0, 12'h000, 2'h0, 16'h0000);
    `CHK("pre one", 4'h6, bank_open)
    op(SDC_PRE, 2'h3, 12'h400, 2'h0, 16'h0000);
    `CHK("pre all", 4'h0, bank_open)
    op(SDC_LMR, 2'h0, 12'h023, 2'h0, 16'h0000);
    `CHK("mode", 12'h023, mode_reg)
    op(sdc_cmd_t'(4'h8), 2'h0, 12'h0FF, 2'h0, 16'h0000);
    `CHK("inhibit", 12'h023, mode_reg)
    $display("test pre done");
  endtask : t_pre
  task automatic t_burst;
    // Burst length is eight from here on
    op(SDC_ACT, 2'h3, 12'h007, 2'h0, 16'h0000);
    op(SDC_RD, 2'h3, 12'h000, 2'h0, 16'h0000);
    op(SDC_BST, 2'h0, 12'h000, 2'h0, 16'h0000);
    i_sdc_ctl_model.nop(4);
    #1;
    `CHK("terminated", 2'h0, dq_oe)
    `CHK("open", 4'h8, bank_open)
    op(SDC_RD, 2'h3, 12'h400, 2'h0, 16'h0000);
    i_sdc_ctl_model.nop(12);
    #1;
    `CHK("read ap", 4'h0, bank_open)
    op(SDC_ACT, 2'h2, 12'h009, 2'h0, 16'h0000);
    op(SDC_WR, 2'h2, 12'h410, 2'h0, 16'h5555);
    i_sdc_ctl_model.nop(12);
    #1;
    `CHK("write ap", 4'h0, bank_open)
    $display("test burst done");
  endtask : t_burst
  task automatic t_ref;
    op(SDC_REF, 2'h3, 12'hFFF, 2'h0, 16'h0000);
    `CHK("auto ref", 14'h0001, refresh_count)
    // Long enough for one internal refresh tick
    i_sdc_ctl_model.sr_enter(790);
    `CHK("self in", 1'b1, self_refresh)
    `CHK("self tick", 14'h0002, refresh_count)
    `CHK("ignored", 4'h0, bank_open)
    i_sdc_ctl_model.sr_exit();
    `CHK("self out", 1'b0, self_refresh)
    op(SDC_REF, 2'h0, 12'h000, 2'h0, 16'h0000);
    `CHK("ref after", 14'h0003, refresh_count)
    $display("test ref done");
  endtask : t_ref
  task automatic t_cl3;
    // Latency three, burst of two, upper lane masked
    op(SDC_LMR, 2'h0, 12'h031, 2'h0, 16'h0000);
    `CHK("mode cl3", 12'h031, mode_reg)
    op(SDC_ACT, 2'h1, 12'h005, 2'h0, 16'h0000);
    i_sdc_ctl_model.send(SDC_RD, 2'h1, 12'h003, 2'h2, 16'h0000);
    i_sdc_ctl_model.nop(1);
    @(posedge clk);
    #1;
    `CHK("cl3 early", 2'h0, dq_oe)
    @(posedge clk);
    #1;
    `CHK("cl3 lanes", 2'h1, dq_oe)
    `CHK("cl3 data", 16'h00CD, dq_out & 16'h00FF)
    @(posedge clk);
    #1;
    `CHK("cl3 beat two", 2'h1, dq_oe)
    @(posedge clk);
    #1;
    `CHK("cl3 burst end", 2'h0, dq_oe)
    $display("test cl3 done");
  endtask : t_cl3
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  initial begin
    resetn = 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    #1;
    `CHK("reset", 34'h200000000,
         {write_ready, bank_open, mode_reg, self_refresh, refresh_count, dq_oe})
    t_rw();
    t_pre();
    t_burst();
    t_ref();
    t_cl3();
    end_sim();
  end
  // Whole run needs under 1100 cycles, mostly the self refresh stay
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    $display("timeout");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
